/* File: rbmc_top.sv */
// Regulator and brown-out mode control with its option register
`timescale 1ns/10ps
module rbmc_top
  import rbmc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  // Special-function register access
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_write_i,
  output logic [7:0]      sfr_rdata_o,
  // Configuration and mode
  input  wire logic [7:0] config_word_high_i,
  input  wire logic       config_load_i,
  input  wire logic [1:0] op_mode_i,
  input  wire logic [3:0] analog_channel_select_i,
  input  wire logic       low_voltage_sense_i,
  // Power controls
  output logic            regulator_enable_o,
  output logic            regulator_bypass_o,
  output logic            brownout_reset_enable_o,
  output logic [1:0]      brownout_level_o,
  output logic            undervoltage_detect_flag_o,
  output logic            supply_noise_filter_o,
  output logic            bandgap_on_o
);

  logic       rst_meta;
  logic       rst_sync_n;
  logic [7:0] misc_option_ctrl;
  logic [7:0] config_word_high;
  logic       sense_meta;
  logic       sense_sync;
  logic       dec_enable;
  logic [1:0] dec_level;
  logic       dec_detect;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Option register; only the bypass bit steers this block, others stored
  always_ff @(posedge clock_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      misc_option_ctrl <= OPT_RESET;
    end else if (clk_en_i && sfr_write_i && sfr_addr_i == OPT_ADDR) begin
      misc_option_ctrl <= sfr_wdata_i;
    end
  end

  // Configuration word captured when the power-on load strobe fires
  always_ff @(posedge clock_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      config_word_high <= CFG_RESET;
    end else if (clk_en_i && config_load_i) begin
      config_word_high <= config_word_high_i;
    end
  end

  // Analog comparator output is asynchronous, so synchronise it
  always_ff @(posedge clock_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sense_meta <= 1'b0;
      sense_sync <= 1'b0;
    end else if (clk_en_i) begin
      sense_meta <= low_voltage_sense_i;
      sense_sync <= sense_meta;
    end
  end

  // Decoder shared by regulator enable, level and detect gating
  rbmc_level_decode u_decode (
    .bypass_i       (misc_option_ctrl[OPT_BYPASS_BIT]),
    .power_save_i   (config_word_high[CFG_PWRSAVE_BIT]),
    .level_field_i  (config_word_high[CFG_LEVEL_LSB+1:CFG_LEVEL_LSB]),
    .mode_i         (op_mode_i),
    .reg_enable_o   (dec_enable),
    .level_o        (dec_level),
    .detect_allow_o (dec_detect)
  );

  // Outputs follow mode changes with no register delay
  always_comb begin
    regulator_enable_o         = dec_enable;
    regulator_bypass_o         = misc_option_ctrl[OPT_BYPASS_BIT];
    brownout_reset_enable_o    = 1'b1;
    brownout_level_o           = dec_level;
    undervoltage_detect_flag_o = dec_detect && sense_sync;
    supply_noise_filter_o      = config_word_high[CFG_FILTER_BIT];
    // Software choice; hardware only reports it
    bandgap_on_o               = (analog_channel_select_i == BANDGAP_CHANNEL);
    sfr_rdata_o                = (sfr_addr_i == OPT_ADDR) ? misc_option_ctrl : SFR_IDLE_DATA;
  end

  // Bypass set keeps the regulator off whatever the mode
  chk_bypass_off: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    misc_option_ctrl[OPT_BYPASS_BIT] |-> !regulator_enable_o)
    else $error("regulator on while bypassed");

  // Neither bypass nor power save: the regulator never drops
  chk_normal_on: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (!misc_option_ctrl[OPT_BYPASS_BIT] && !config_word_high[CFG_PWRSAVE_BIT]) |-> regulator_enable_o)
    else $error("regulator off without cause");

  // Power save alone switches the regulator off in Stop only
  chk_stop_save: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (!misc_option_ctrl[OPT_BYPASS_BIT] && config_word_high[CFG_PWRSAVE_BIT])
      |-> (regulator_enable_o == (op_mode_i != MODE_STOP)))
    else $error("power save regulator mismatch");

  // Bypass clear outside Stop always keeps the core supplied
  chk_run_on: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (!misc_option_ctrl[OPT_BYPASS_BIT] && op_mode_i != MODE_STOP) |-> regulator_enable_o)
    else $error("regulator off outside stop");

  // Forced lowest level also masks the detect flag
  chk_forced_level: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (config_word_high[CFG_PWRSAVE_BIT] && (op_mode_i == MODE_STOP || misc_option_ctrl[OPT_BYPASS_BIT]))
      |-> (brownout_level_o == LVL_1V8 && !undervoltage_detect_flag_o))
    else $error("power save level not forced");

  // Power save outside Stop leaves an unbypassed level alone
  chk_save_run_level: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (config_word_high[CFG_PWRSAVE_BIT] && !misc_option_ctrl[OPT_BYPASS_BIT] && op_mode_i != MODE_STOP)
      |-> brownout_level_o == config_word_high[CFG_LEVEL_LSB+1:CFG_LEVEL_LSB])
    else $error("level forced outside stop");

  // Without power save the level field passes through untouched
  chk_level_pass: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    !config_word_high[CFG_PWRSAVE_BIT] |-> brownout_level_o == config_word_high[CFG_LEVEL_LSB+1:CFG_LEVEL_LSB])
    else $error("level field not followed");

  // Detect flag only exists at the lowest brown-out level
  chk_detect_level: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    undervoltage_detect_flag_o |-> brownout_level_o == LVL_1V8)
    else $error("detect at high level");

  // A higher level in the field keeps the flag dark
  chk_detect_field: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (config_word_high[CFG_LEVEL_LSB+1:CFG_LEVEL_LSB] != LVL_1V8) |-> !undervoltage_detect_flag_o)
    else $error("detect with high level field");

  // Lowest level without power save must pass the sensed condition
  chk_detect_pass: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (!config_word_high[CFG_PWRSAVE_BIT] && sense_sync
      && config_word_high[CFG_LEVEL_LSB+1:CFG_LEVEL_LSB] == LVL_1V8) |-> undervoltage_detect_flag_o)
    else $error("detect flag withheld");

  // Power save while running with bypass clear keeps the flag usable at the lowest level
  chk_save_run_flag: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (config_word_high[CFG_PWRSAVE_BIT] && !misc_option_ctrl[OPT_BYPASS_BIT] && op_mode_i != MODE_STOP
      && config_word_high[CFG_LEVEL_LSB+1:CFG_LEVEL_LSB] == LVL_1V8 && sense_sync)
      |-> undervoltage_detect_flag_o)
    else $error("flag lost outside stop");

  // Flag never rises without the synchronised comparator
  chk_detect_sense: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    undervoltage_detect_flag_o |-> sense_sync)
    else $error("detect flag without sense");

  // Bypass together with power save silences the flag
  chk_detect_off: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (misc_option_ctrl[OPT_BYPASS_BIT] && config_word_high[CFG_PWRSAVE_BIT]) |-> !undervoltage_detect_flag_o)
    else $error("detect not disabled");

  // Brown-out reset can never be switched off
  chk_brownout_on: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    brownout_reset_enable_o)
    else $error("brown-out reset inactive");

  // Bypass bit lands on the edge that takes the write
  chk_bypass_write: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (clk_en_i && sfr_write_i && sfr_addr_i == OPT_ADDR) |=> regulator_bypass_o == $past(sfr_wdata_i[OPT_BYPASS_BIT]))
    else $error("bypass write lost");

  // Option register only moves on an accepted write
  chk_option_hold: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    !(clk_en_i && sfr_write_i && sfr_addr_i == OPT_ADDR) |=> $stable(misc_option_ctrl))
    else $error("option register changed unasked");

  // Read port shows the option register at its address
  chk_rdata_option: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (sfr_addr_i == OPT_ADDR) |-> sfr_rdata_o == misc_option_ctrl)
    else $error("option read mismatch");

  // Any other address reads as idle data
  chk_rdata_idle: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (sfr_addr_i != OPT_ADDR) |-> sfr_rdata_o == SFR_IDLE_DATA)
    else $error("unmapped read not idle");

  // Bypass output mirrors the stored bit
  chk_bypass_mirror: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    regulator_bypass_o == misc_option_ctrl[OPT_BYPASS_BIT])
    else $error("bypass output stale");

  // Filter bit captured with the configuration word
  chk_filter_load: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (clk_en_i && config_load_i) |=> supply_noise_filter_o == $past(config_word_high_i[CFG_FILTER_BIT]))
    else $error("filter bit not loaded");

  // Filter output tracks the stored configuration between loads
  chk_filter_follow: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    supply_noise_filter_o == config_word_high[CFG_FILTER_BIT])
    else $error("filter output stale");

  // Loaded power-save bit of 0 keeps the regulator on while bypass is clear
  chk_save_load: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (clk_en_i && config_load_i && !config_word_high_i[CFG_PWRSAVE_BIT]) ##1 !misc_option_ctrl[OPT_BYPASS_BIT]
      |-> regulator_enable_o)
    else $error("power save bit misread");

  // Configuration only moves on a load strobe with the enable high
  chk_config_hold: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    !(clk_en_i && config_load_i) |=> $stable(config_word_high))
    else $error("configuration changed unasked");

  // Clock enable low also freezes the comparator synchroniser
  chk_sense_freeze: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    !clk_en_i |=> $stable(sense_sync))
    else $error("sense moved while frozen");

  // Bandgap report follows the channel code; software keeps it clear
  chk_bandgap_report: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    bandgap_on_o == (analog_channel_select_i == BANDGAP_CHANNEL))
    else $error("bandgap report wrong");

endmodule

/* File: rbmc_pkg.sv */
// Package of constants and encodings for the regulator and brown-out mode control
package rbmc_pkg;

  // Option register location and fields
  localparam logic [7:0] OPT_ADDR        = 8'h94;
  localparam logic [7:0] OPT_RESET       = 8'h00;
  localparam int         OPT_BYPASS_BIT  = 6;

  // High configuration word fields
  localparam int         CFG_PWRSAVE_BIT = 2;
  localparam int         CFG_FILTER_BIT  = 3;
  localparam int         CFG_LEVEL_LSB   = 4;
  // Configuration word held until the first load strobe
  localparam logic [7:0] CFG_RESET       = 8'h00;
  // Read data for addresses this block does not own
  localparam logic [7:0] SFR_IDLE_DATA   = 8'h00;

  // Analog channel code that keeps the bandgap on
  localparam logic [3:0] BANDGAP_CHANNEL = 4'hB;

  // Brown-out level encodings
  localparam logic [1:0] LVL_2V9 = 2'h0;
  localparam logic [1:0] LVL_2V3 = 2'h1;
  localparam logic [1:0] LVL_3V5 = 2'h2;
  localparam logic [1:0] LVL_1V8 = 2'h3;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_FAST,
    MODE_SLOW,
    MODE_IDLE,
    MODE_STOP
  } rbmc_mode_e;

endpackage

/* File: rbmc_level_decode.sv */
// Combinational decoder for regulator enable and effective brown-out level
`timescale 1ns/10ps
module rbmc_level_decode
  import rbmc_pkg::*;
(
  // Controls
  input  wire logic       bypass_i,
  input  wire logic       power_save_i,
  input  wire logic [1:0] level_field_i,
  input  wire logic [1:0] mode_i,
  // Results
  output logic            reg_enable_o,
  output logic [1:0]      level_o,
  output logic            detect_allow_o
);

  logic stop_mode;
  logic forced;

  // Power save overrides only in Stop, or always once bypassed
  always_comb begin
    stop_mode      = (mode_i == MODE_STOP);
    forced         = power_save_i && (stop_mode || bypass_i);
    reg_enable_o   = !bypass_i && !(power_save_i && stop_mode);
    level_o        = forced ? LVL_1V8 : level_field_i;
    detect_allow_o = !forced && (level_field_i == LVL_1V8)
                     && !(bypass_i && power_save_i);
  end

endmodule

/* File: tb.sv */
// Self-checking bench for the regulator and brown-out mode control
`timescale 1ns/10ps
module tb
  import rbmc_pkg::*;
;
  typedef struct packed {
    logic       byp;
    logic [7:0] cfg;
    logic [1:0] mode;
    logic       en;
    logic [1:0] lvl;
    logic       flg;
  } rbmc_row_s;
  logic       clk = 0, rst_n = 0, cen = 1, wr = 0, ld = 0, sense = 1;
  logic [7:0] addr = 8'h94, wd = 8'h00, cfg = 8'h00, rd;
  logic [1:0] mode = 2'h0, lvl;
  logic [3:0] ch = 4'h0;
  logic       en, byp, bre, flg, flt, bg;
  int         bad_count = 0, tests_run = 0;
  // Bypass, config word, mode, then expected enable, level, detect flag
  rbmc_row_s  rows [8] = '{'{0, 8'h00, 2'h0, 1, 2'h0, 0}, '{0, 8'h34, 2'h2, 1, 2'h3, 1},
                           '{0, 8'h34, 2'h3, 0, 2'h3, 0}, '{0, 8'h30, 2'h3, 1, 2'h3, 1},
                           '{1, 8'h10, 2'h1, 0, 2'h1, 0}, '{1, 8'h24, 2'h0, 0, 2'h3, 0},
                           '{1, 8'h30, 2'h3, 0, 2'h3, 1}, '{0, 8'h20, 2'h1, 1, 2'h2, 0}};

  rbmc_top rbmc_top_inst (.clock_i(clk), .reset_n_i(rst_n), .clk_en_i(cen), .sfr_addr_i(addr),
    .sfr_wdata_i(wd), .sfr_write_i(wr), .sfr_rdata_o(rd), .config_word_high_i(cfg), .config_load_i(ld),
    .op_mode_i(mode), .analog_channel_select_i(ch), .low_voltage_sense_i(sense), .regulator_enable_o(en),
    .regulator_bypass_o(byp), .brownout_reset_enable_o(bre), .brownout_level_o(lvl),
    .undervoltage_detect_flag_o(flg), .supply_noise_filter_o(flt), .bandgap_on_o(bg));

  // Free-running 100 MHz clock
  initial forever #5 clk = ~clk;

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One write strobe; address is left in place so the read can follow
  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic e);
    @(negedge clk); addr = a; wd = d; cen = e; wr = 1;
    @(negedge clk); wr = 0; cen = 1;
  endtask
  task automatic load(input logic [7:0] w);
    @(negedge clk); cfg = w; ld = 1;
    @(negedge clk); ld = 0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence: reset, table of modes, then corner cases
  initial begin
    repeat (16) @(negedge clk);
    chk("rdata_rst", rd, OPT_RESET);
    chk("en_rst", en, 1);
    chk("lvl_rst", lvl, LVL_2V9);
    rst_n = 1;
    repeat (4) @(negedge clk);
    $display("reset test done");
    foreach (rows[i]) begin
      sfr(OPT_ADDR, rows[i].byp ? 8'h40 : 8'h00, 1);
      load(rows[i].cfg);
      mode = rows[i].mode;
      repeat (3) @(negedge clk);
      chk("reg_en", en, rows[i].en);
      chk("level", lvl, rows[i].lvl);
      chk("flag", flg, rows[i].flg);
      chk("bor_en", bre, 1);
      chk("bypass", byp, rows[i].byp);
      chk("rdata", rd, {1'b0, rows[i].byp, 6'h00});
    end
    $display("table test done");
    // Mode change must act in the same cycle, no clock edge needed
    sfr(OPT_ADDR, 8'h00, 1);
    load(8'h04);
    @(negedge clk);
    mode = MODE_STOP;
    #1;
    chk("stop_en", en, 0);
    chk("stop_lvl", lvl, LVL_1V8);
    @(negedge clk);
    mode = MODE_IDLE;
    #1;
    chk("idle_en", en, 1);
    // Writes with the enable low or to another address are dropped
    sfr(OPT_ADDR, 8'hFF, 0);
    chk("gated_wr", rd, 8'h00);
    sfr(8'h95, 8'hA5, 1);
    chk("unmapped", rd, 8'h00);
    addr = OPT_ADDR; #1;
    chk("opt_kept", rd, 8'h00);
    sfr(OPT_ADDR, 8'hFF, 1);
    chk("opt_rw", rd, 8'hFF);
    chk("byp_off", en, 0);
    $display("register test done");
    load(8'h08);
    chk("filter", flt, 1);
    ch = BANDGAP_CHANNEL; #1;
    chk("bandgap", bg, 1);
    @(negedge clk);
    ch = 4'hA;
    #1;
    chk("bandgap_off", bg, 0);
    // Sense path: flag follows the comparator only at the lowest level
    load(8'h30);
    sense = 0;
    repeat (3) @(negedge clk);
    chk("flag_low", flg, 0);
    sense = 1;
    repeat (3) @(negedge clk);
    chk("flag_high", flg, 1);
    // Reset in mid-run clears the option register at once
    rst_n = 0; #1;
    chk("rdata_rst2", rd, 8'h00);
    chk("filter_rst", flt, 0);
    @(negedge clk);
    rst_n = 1;
    // Two synchroniser edges, then the reset state must show again
    repeat (3) @(negedge clk);
    chk("en_rel", en, 1);
    chk("lvl_rel", lvl, LVL_2V9);
    chk("byp_rel", byp, 0);
    $display("misc test done");
    summarize();
  end
endmodule
